//--- rtl/ivag_pkg.sv
// Function
// RULE1: each vector entry is four consecutive bytes
// RULE2: accepted interrupt branches to its entry's address
// RULE3: low byte at lowest entry address
// RULE4: fixed table spans FFFDC to FFFFF
// RULE5: undefined opcode trap uses entry FFFDC
// RULE6: overflow trap uses entry FFFE0
// RULE7: break uses FFFE4, relocatable zero if FF
// RULE8: address match FFFE8, pin NMI FFFF8, reset FFFFC
// RULE9: watchdog, oscillation, low voltage share FFFF0
// RULE10: single step and debugger vectors reserved
// RULE11: fixed entry high byte goes to ID check
// RULE12: relocatable table is 256 bytes from base
// RULE13: even base fetches faster than odd base
// RULE14: relocatable entry n at base plus 4n
// RULE15: relocatable numbers 1 to 13 fixed sources
// RULE16: bus collision uses relocatable number 10
// RULE17: base timer and I2C lines share number 7
// RULE18: relocatable addresses relative to table base
// RULE19: branch target is vector's lower 20 bits
// RULE20: shared sources yield the same entry address
package ivag_pkg;

  localparam int ADDR_W      = 20;
  localparam int DATA_W      = 16;
  localparam int NUM_W       = 6;
  localparam int KIND_W      = 4;
  localparam int VEC_BYTES   = 4;   // [RULE1]
  localparam int RELOC_BYTES = 256; // [RULE12]

  // ****************************************************************
  // fixed vector entry start addresses and table end
  // ****************************************************************
  localparam logic [19:0] FIX_UNDEF_OPCODE = 20'hF_FFDC; // [RULE4] [RULE5]
  localparam logic [19:0] FIX_OVERFLOW     = 20'hF_FFE0; // [RULE6]
  localparam logic [19:0] FIX_BREAK        = 20'hF_FFE4; // [RULE7]
  localparam logic [19:0] FIX_ADDR_MATCH   = 20'hF_FFE8; // [RULE8]
  localparam logic [19:0] FIX_SINGLE_STEP  = 20'hF_FFEC; // [RULE10]
  localparam logic [19:0] FIX_WATCHDOG     = 20'hF_FFF0; // [RULE9]
  localparam logic [19:0] FIX_DEBUG_BREAK  = 20'hF_FFF4; // [RULE10]
  localparam logic [19:0] FIX_NMI_PIN      = 20'hF_FFF8; // [RULE8]
  localparam logic [19:0] FIX_RESET        = 20'hF_FFFC; // [RULE8]
  localparam logic [19:0] FIX_TABLE_END    = 20'hF_FFFF; // [RULE4]

  localparam logic [7:0] BREAK_REDIRECT_BYTE = 8'hFF; // [RULE7]

  // ****************************************************************
  // request kinds
  // ****************************************************************
  localparam logic [3:0] KIND_UNDEF_OPCODE = 4'h0;
  localparam logic [3:0] KIND_OVERFLOW     = 4'h1;
  localparam logic [3:0] KIND_BREAK        = 4'h2;
  localparam logic [3:0] KIND_ADDR_MATCH   = 4'h3;
  localparam logic [3:0] KIND_SINGLE_STEP  = 4'h4;
  localparam logic [3:0] KIND_WATCHDOG     = 4'h5;
  localparam logic [3:0] KIND_OSC_STOP     = 4'h6;
  localparam logic [3:0] KIND_LOW_VOLTAGE  = 4'h7;
  localparam logic [3:0] KIND_DEBUG_BREAK  = 4'h8;
  localparam logic [3:0] KIND_NMI_PIN      = 4'h9;
  localparam logic [3:0] KIND_RESET        = 4'hA;
  localparam logic [3:0] KIND_RELOCATABLE  = 4'hB;

  // ****************************************************************
  // relocatable entry numbers
  // ****************************************************************
  localparam logic [5:0] NUM_BREAK_INSTR        = 6'h00; // [RULE14]
  localparam logic [5:0] NUM_BUSCTL_WAKEUP      = 6'h01; // [RULE15]
  localparam logic [5:0] NUM_BUSCTL_RX_DONE     = 6'h02;
  localparam logic [5:0] NUM_BUSCTL_TX_DONE     = 6'h03;
  localparam logic [5:0] NUM_EXT_INPUT3         = 6'h04;
  localparam logic [5:0] NUM_CAPCMP_0           = 6'h05;
  localparam logic [5:0] NUM_CAPCMP_1_I2C       = 6'h06; // [RULE20]
  localparam logic [5:0] NUM_CAPCMP_BASE_I2C_LN = 6'h07; // [RULE17] [RULE20]
  localparam logic [5:0] NUM_SERIAL4_EXT5       = 6'h08; // [RULE20]
  localparam logic [5:0] NUM_SERIAL3_EXT4       = 6'h09; // [RULE20]
  localparam logic [5:0] NUM_UART2_COLLISION    = 6'h0A; // [RULE16]
  localparam logic [5:0] NUM_DMA_CHANNEL_ZERO   = 6'h0B;
  localparam logic [5:0] NUM_DMA_CHANNEL_ONE    = 6'h0C;
  localparam logic [5:0] NUM_BUSCTL_STATE_ERR   = 6'h0D; // [RULE15]

  typedef enum logic [0:0] {
    IVAG_IDLE,
    IVAG_READ
  } ivag_state_t;

endpackage : ivag_pkg

//--- rtl/ivag_top.sv
`timescale 1ns/100ps
`default_nettype none
module ivag_top (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        req_valid_i,
  input  wire logic [3:0]  req_kind_i,
  input  wire logic [5:0]  req_num_i,
  input  wire logic [19:0] vector_table_base_i,
  input  wire logic        mem_ack_i,
  input  wire logic [15:0] mem_rdata_i,
  output logic             busy_o,
  output logic             mem_rd_o,
  output logic             mem_word_o,
  output logic [19:0]      mem_addr_o,
  output logic [19:0]      entry_addr_o,
  output logic [19:0]      target_o,
  output logic             target_valid_o,
  output logic [7:0]       id_byte_o,
  output logic             id_valid_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  ivag_pkg::ivag_state_t state_r;
  logic                  busy_r;
  logic                  mem_rd_r;
  logic                  mem_word_r;
  logic [19:0]           mem_addr_r;
  logic [19:0]           entry_r;
  logic [3:0]            kind_r;
  logic                  fixed_r;
  logic [1:0]            idx_r;
  logic [31:0]           vec_r;
  logic [19:0]           target_r;
  logic                  target_valid_r;
  logic [7:0]            id_byte_r;
  logic                  id_valid_r;

  logic                  take;
  logic [19:0]           entry_nxt;
  logic [31:0]           vec_nxt;
  logic [2:0]            idx_nxt;
  logic                  last;
  logic                  brk_redirect;

  assign take = (state_r == ivag_pkg::IVAG_IDLE) && req_valid_i;

  // ****************************************************************
  // entry address decode
  // ****************************************************************
  // shared sources decode to one entry; software finds the cause
  always_comb begin
    case (req_kind_i)
      ivag_pkg::KIND_UNDEF_OPCODE: entry_nxt = ivag_pkg::FIX_UNDEF_OPCODE; // [RULE5]
      ivag_pkg::KIND_OVERFLOW:     entry_nxt = ivag_pkg::FIX_OVERFLOW;     // [RULE6]
      ivag_pkg::KIND_BREAK:        entry_nxt = ivag_pkg::FIX_BREAK;        // [RULE7]
      ivag_pkg::KIND_ADDR_MATCH:   entry_nxt = ivag_pkg::FIX_ADDR_MATCH;   // [RULE8]
      ivag_pkg::KIND_SINGLE_STEP:  entry_nxt = ivag_pkg::FIX_SINGLE_STEP;
      ivag_pkg::KIND_WATCHDOG,
      ivag_pkg::KIND_OSC_STOP,
      ivag_pkg::KIND_LOW_VOLTAGE:  entry_nxt = ivag_pkg::FIX_WATCHDOG;     // [RULE9] [RULE20]
      ivag_pkg::KIND_DEBUG_BREAK:  entry_nxt = ivag_pkg::FIX_DEBUG_BREAK;
      ivag_pkg::KIND_NMI_PIN:      entry_nxt = ivag_pkg::FIX_NMI_PIN;      // [RULE8]
      ivag_pkg::KIND_RESET:        entry_nxt = ivag_pkg::FIX_RESET;        // [RULE8]
      // 6-bit number times four keeps the offset inside 256 bytes
      default:                     entry_nxt = 20'(vector_table_base_i + {12'h000, req_num_i, 2'b00}); // [RULE12] [RULE14] [RULE18]
    endcase
  end

  // ****************************************************************
  // byte assembly, little endian
  // ****************************************************************
  always_comb begin
    vec_nxt = vec_r;
    if (mem_word_r) begin
      case (idx_r)
        2'd0:    vec_nxt[15:0]  = mem_rdata_i; // [RULE3]
        default: vec_nxt[31:16] = mem_rdata_i;
      endcase
    end else begin
      case (idx_r)
        2'd0:    vec_nxt[7:0]   = mem_rdata_i[7:0]; // [RULE3]
        2'd1:    vec_nxt[15:8]  = mem_rdata_i[7:0];
        2'd2:    vec_nxt[23:16] = mem_rdata_i[7:0];
        default: vec_nxt[31:24] = mem_rdata_i[7:0];
      endcase
    end
  end

  // odd entries fall back to four byte reads, hence the slower sequence
  assign idx_nxt = {1'b0, idx_r} + (mem_word_r ? 3'd2 : 3'd1); // [RULE13]
  assign last    = (idx_nxt == 3'(ivag_pkg::VEC_BYTES));        // [RULE1]

  // byte at FFFE7 is the high byte of the fixed break entry
  assign brk_redirect = fixed_r && (kind_r == ivag_pkg::KIND_BREAK) &&
                        (vec_nxt[31:24] == ivag_pkg::BREAK_REDIRECT_BYTE); // [RULE7]

  // ****************************************************************
  // fetch sequencer
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      state_r    <= ivag_pkg::IVAG_IDLE;
      busy_r     <= 1'b0;
      mem_rd_r   <= 1'b0;
      mem_word_r <= 1'b0;
      mem_addr_r <= 20'h0_0000;
      entry_r    <= 20'h0_0000;
      kind_r     <= 4'h0;
      fixed_r    <= 1'b0;
      idx_r      <= 2'd0;
    end else begin
      case (state_r)
        ivag_pkg::IVAG_IDLE: begin
          if (req_valid_i) begin
            entry_r    <= entry_nxt;
            mem_addr_r <= entry_nxt;
            mem_word_r <= ~entry_nxt[0]; // [RULE13]
            kind_r     <= req_kind_i;
            fixed_r    <= (req_kind_i < ivag_pkg::KIND_RELOCATABLE);
            idx_r      <= 2'd0;
            mem_rd_r   <= 1'b1;
            busy_r     <= 1'b1;
            state_r    <= ivag_pkg::IVAG_READ;
          end
        end
        ivag_pkg::IVAG_READ: begin
          if (mem_ack_i) begin
            if (last && brk_redirect) begin
              // restart on relocatable entry zero, base plus nothing
              entry_r    <= vector_table_base_i;   // [RULE7] [RULE14]
              mem_addr_r <= vector_table_base_i;
              mem_word_r <= ~vector_table_base_i[0];
              fixed_r    <= 1'b0;
              idx_r      <= 2'd0;
            end else if (last) begin
              mem_rd_r <= 1'b0;
              busy_r   <= 1'b0;
              state_r  <= ivag_pkg::IVAG_IDLE;
            end else begin
              idx_r      <= idx_nxt[1:0];
              mem_addr_r <= 20'(entry_r + {17'h0_0000, idx_nxt}); // [RULE1]
            end
          end
        end
        default: state_r <= ivag_pkg::IVAG_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      vec_r <= 32'h0000_0000;
    end else if (take) begin
      vec_r <= 32'h0000_0000;
    end else if ((state_r == ivag_pkg::IVAG_READ) && mem_ack_i) begin
      vec_r <= vec_nxt;
    end
  end

  // ****************************************************************
  // results
  // ****************************************************************
  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      target_r       <= 20'h0_0000;
      target_valid_r <= 1'b0;
    end else begin
      target_valid_r <= 1'b0;
      if ((state_r == ivag_pkg::IVAG_READ) && mem_ack_i && last && !brk_redirect) begin
        target_r       <= vec_nxt[19:0]; // [RULE2] [RULE19]
        target_valid_r <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (srst_i) begin
      id_byte_r  <= 8'h00;
      id_valid_r <= 1'b0;
    end else begin
      id_valid_r <= 1'b0;
      if ((state_r == ivag_pkg::IVAG_READ) && mem_ack_i && last && fixed_r) begin
        id_byte_r  <= vec_nxt[31:24]; // [RULE11]
        id_valid_r <= 1'b1;
      end
    end
  end

  assign busy_o         = busy_r;
  assign mem_rd_o       = mem_rd_r;
  assign mem_word_o     = mem_word_r;
  assign mem_addr_o     = mem_addr_r;
  assign entry_addr_o   = entry_r;
  assign target_o       = target_r;
  assign target_valid_o = target_valid_r;
  assign id_byte_o      = id_byte_r;
  assign id_valid_o     = id_valid_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (srst_i);

  sequence brk_high_ff_s;
    (state_r == ivag_pkg::IVAG_READ) && mem_ack_i && last && brk_redirect;
  endsequence

  sequence reloc_zero_fetch_s;
    mem_rd_o && !fixed_r && (mem_addr_o == $past(vector_table_base_i));
  endsequence

  sequence reloc_start_s;
    $rose(busy_o) && !fixed_r;
  endsequence

  sequence fixed_start_s;
    $rose(busy_o) && fixed_r;
  endsequence

  sequence read_waiting_s;
    mem_rd_o && !mem_ack_i;
  endsequence

  undef_entry_a: assert property ( // [RULE5]
    take && (req_kind_i == ivag_pkg::KIND_UNDEF_OPCODE) |=>
      mem_rd_o && (mem_addr_o == ivag_pkg::FIX_UNDEF_OPCODE))
    else $error("undefined opcode entry address wrong");

  overflow_entry_a: assert property ( // [RULE6]
    take && (req_kind_i == ivag_pkg::KIND_OVERFLOW) |=> (mem_addr_o == ivag_pkg::FIX_OVERFLOW))
    else $error("overflow entry address wrong");

  shared_watchdog_a: assert property ( // [RULE9]
    take && ((req_kind_i == ivag_pkg::KIND_OSC_STOP) || (req_kind_i == ivag_pkg::KIND_LOW_VOLTAGE)) |=>
      (entry_addr_o == ivag_pkg::FIX_WATCHDOG))
    else $error("shared watchdog entry not used");

  reloc_entry_a: assert property ( // [RULE14]
    take && (req_kind_i == ivag_pkg::KIND_RELOCATABLE) |=>
      (mem_addr_o == 20'($past(vector_table_base_i) + {12'h000, $past(req_num_i), 2'b00})))
    else $error("relocatable entry not at base plus four n");

  word_even_a: assert property ( // [RULE13]
    mem_rd_o && mem_word_o |-> !mem_addr_o[0])
    else $error("word read at odd address");

  odd_base_byte_a: assert property ( // [RULE13]
    take && (req_kind_i == ivag_pkg::KIND_RELOCATABLE) && vector_table_base_i[0] |=> !mem_word_o)
    else $error("odd base must use byte reads");

  fixed_range_a: assert property ( // [RULE4]
    mem_rd_o && fixed_r |-> (mem_addr_o >= ivag_pkg::FIX_UNDEF_OPCODE))
    else $error("fixed fetch outside fixed table");

  break_redirect_a: assert property ( // [RULE7]
    brk_high_ff_s |=> reloc_zero_fetch_s ##0 !target_valid_o)
    else $error("break did not fall back to relocatable zero");

  target_pulse_a: assert property ( // [RULE2]
    target_valid_o |-> $past(mem_ack_i) && !busy_o ##1 !target_valid_o)
    else $error("target valid not a single pulse after last read");

  id_check_a: assert property ( // [RULE11]
    id_valid_o |-> $past(fixed_r) && (id_byte_o == $past(vec_nxt[31:24])))
    else $error("id byte not from a fixed entry high byte");

  // ****************************************************************
  // entry map
  // ****************************************************************
  break_entry_a: assert property ( // [RULE7]
    take && (req_kind_i == ivag_pkg::KIND_BREAK) |=> (mem_addr_o == ivag_pkg::FIX_BREAK))
    else $error("break entry address wrong");

  addr_match_entry_a: assert property ( // [RULE8]
    take && (req_kind_i == ivag_pkg::KIND_ADDR_MATCH) |=> (mem_addr_o == ivag_pkg::FIX_ADDR_MATCH))
    else $error("address match entry address wrong");

  nmi_entry_a: assert property ( // [RULE8]
    take && (req_kind_i == ivag_pkg::KIND_NMI_PIN) |=> (mem_addr_o == ivag_pkg::FIX_NMI_PIN))
    else $error("pin interrupt entry address wrong");

  reset_entry_a: assert property ( // [RULE8]
    take && (req_kind_i == ivag_pkg::KIND_RESET) |=> (mem_addr_o == ivag_pkg::FIX_RESET))
    else $error("reset entry address wrong");

  watchdog_entry_a: assert property ( // [RULE9] [RULE20]
    take && (req_kind_i == ivag_pkg::KIND_WATCHDOG) |=> (entry_addr_o == ivag_pkg::FIX_WATCHDOG))
    else $error("watchdog entry address wrong");

  fixed_aligned_a: assert property ( // [RULE1] [RULE4]
    fixed_start_s |-> (entry_addr_o >= ivag_pkg::FIX_UNDEF_OPCODE) && (entry_addr_o[1:0] == 2'b00))
    else $error("fixed entry not on a four byte slot of the table");

  reloc_zero_a: assert property ( // [RULE14]
    reloc_start_s ##0 ($past(req_num_i) == ivag_pkg::NUM_BREAK_INSTR) |->
      (entry_addr_o == $past(vector_table_base_i)))
    else $error("relocatable entry zero not at the base");

  reloc_window_a: assert property ( // [RULE12] [RULE18]
    reloc_start_s |-> (20'(entry_addr_o - $past(vector_table_base_i)) < 20'(ivag_pkg::RELOC_BYTES)))
    else $error("relocatable entry outside the table");

  shared_timer_a: assert property ( // [RULE17] [RULE20]
    reloc_start_s ##0 ($past(req_num_i) == ivag_pkg::NUM_CAPCMP_BASE_I2C_LN) |->
      (entry_addr_o == 20'($past(vector_table_base_i) +
                           20'(ivag_pkg::NUM_CAPCMP_BASE_I2C_LN) * 20'(ivag_pkg::VEC_BYTES))))
    else $error("base timer and line interrupt entry wrong");

  collision_entry_a: assert property ( // [RULE16]
    reloc_start_s ##0 ($past(req_num_i) == ivag_pkg::NUM_UART2_COLLISION) |->
      (entry_addr_o == 20'($past(vector_table_base_i) +
                           20'(ivag_pkg::NUM_UART2_COLLISION) * 20'(ivag_pkg::VEC_BYTES))))
    else $error("bus collision entry wrong");

  state_err_entry_a: assert property ( // [RULE15]
    reloc_start_s ##0 ($past(req_num_i) == ivag_pkg::NUM_BUSCTL_STATE_ERR) |->
      (entry_addr_o == 20'($past(vector_table_base_i) +
                           20'(ivag_pkg::NUM_BUSCTL_STATE_ERR) * 20'(ivag_pkg::VEC_BYTES))))
    else $error("bus controller state entry wrong");

  // ****************************************************************
  // fetch sequencing
  // ****************************************************************
  read_hold_a: assert property ( // [RULE1]
    read_waiting_s |=> mem_rd_o && $stable(mem_addr_o) && $stable(mem_word_o))
    else $error("read request changed before its answer");

  byte_step_a: assert property ( // [RULE3]
    mem_rd_o && mem_ack_i && !mem_word_o && !last |=>
      (mem_addr_o == 20'($past(mem_addr_o) + 20'h0_0001)))
    else $error("byte reads not in rising address order");

  word_step_a: assert property ( // [RULE3]
    mem_rd_o && mem_ack_i && mem_word_o && !last |=>
      (mem_addr_o == 20'($past(mem_addr_o) + 20'h0_0002)))
    else $error("word reads not in rising address order");

  even_word_a: assert property ( // [RULE13]
    $rose(busy_o) && !entry_addr_o[0] |-> mem_word_o)
    else $error("even entry must use word reads");

  busy_release_a: assert property ( // [RULE2]
    $fell(busy_o) && !$past(srst_i) |-> target_valid_o)
    else $error("fetch ended without a branch target");

  idle_no_read_a: assert property ( // [RULE2]
    !busy_o |-> !mem_rd_o)
    else $error("memory read outside a fetch");

  busy_ignore_a: assert property ( // [RULE2]
    busy_o && req_valid_i && !brk_redirect |=> $stable(entry_addr_o))
    else $error("request taken while busy");

  id_with_target_a: assert property ( // [RULE11]
    target_valid_o && fixed_r |-> id_valid_o)
    else $error("fixed entry high byte not handed to id check");

endmodule : ivag_top
`default_nettype wire

//--- tb/ivag_mem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ivag_mem_model (
  input  wire logic        clk_sys_i,
  input  wire logic        srst_i,
  input  wire logic        mem_rd_i,
  input  wire logic        mem_word_i,
  input  wire logic [19:0] mem_addr_i,
  output logic             mem_ack_o,
  output logic [15:0]      mem_rdata_o
);
  // ****************************************************************
  // byte memory answering after a settable wait
  // ****************************************************************
  logic [7:0] mem [logic [19:0]];
  int         wait_cycles = 0;
  int         ack_count   = 0;
  int         cnt_r       = 0;

  function automatic logic [7:0] rd_byte(input logic [19:0] a);
    return mem.exists(a) ? mem[a] : 8'h00;
  endfunction : rd_byte

  initial begin
    mem_ack_o   = 1'b0;
    mem_rdata_o = 16'h5A5A;
  end

  // idle data toggles so a stale bus never looks valid
  always @(posedge clk_sys_i) begin
    if (srst_i || !mem_rd_i || mem_ack_o) begin
      mem_ack_o   <= 1'b0;
      cnt_r       <= 0;
      mem_rdata_o <= ~mem_rdata_o;
    end else if (cnt_r >= wait_cycles) begin
      mem_ack_o   <= 1'b1;
      ack_count   <= ack_count + 1;
      mem_rdata_o <= {mem_word_i ? rd_byte(mem_addr_i + 20'h0_0001) : ~rd_byte(mem_addr_i),
                      rd_byte(mem_addr_i)};
    end else begin
      cnt_r       <= cnt_r + 1;
      mem_rdata_o <= ~mem_rdata_o;
    end
  end
endmodule : ivag_mem_model
`default_nettype wire

//--- tb/tb_interrupt_vector_address_gen.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin fail_count++; $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module tb_interrupt_vector_address_gen;
  logic        clk_sys_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        req_valid_i = 1'b0;
  logic [3:0]  req_kind_i = 4'h0;
  logic [5:0]  req_num_i = 6'h00;
  logic [19:0] vector_table_base_i = 20'h0_4000;
  logic        mem_ack_i, busy_o, mem_rd_o, mem_word_o, target_valid_o, id_valid_o;
  logic [15:0] mem_rdata_i;
  logic [19:0] mem_addr_o, entry_addr_o, target_o;
  logic [7:0]  id_byte_o;
  int          fail_count = 0;
  int          n_tests = 0;

  always #10 clk_sys_i = ~clk_sys_i;

  ivag_top DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .req_valid_i(req_valid_i), .req_kind_i(req_kind_i),
    .req_num_i(req_num_i), .vector_table_base_i(vector_table_base_i), .mem_ack_i(mem_ack_i),
    .mem_rdata_i(mem_rdata_i), .busy_o(busy_o), .mem_rd_o(mem_rd_o), .mem_word_o(mem_word_o),
    .mem_addr_o(mem_addr_o), .entry_addr_o(entry_addr_o), .target_o(target_o),
    .target_valid_o(target_valid_o), .id_byte_o(id_byte_o), .id_valid_o(id_valid_o));
  ivag_mem_model u_mem (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .mem_rd_i(mem_rd_o), .mem_word_i(mem_word_o),
    .mem_addr_i(mem_addr_o), .mem_ack_o(mem_ack_i), .mem_rdata_o(mem_rdata_i));

  // ****************************************************************
  // helpers
  // ****************************************************************
  // bits 23:20 set on purpose: they must not reach the target
  function automatic logic [31:0] vec_of(input logic [19:0] e);
    return {e[7:0] ^ 8'h3C, 4'h7, e ^ 20'h1_2345};
  endfunction : vec_of

  task automatic put_vec(input logic [19:0] e);
    logic [31:0] v;
    v = vec_of(e);
    for (int i = 0; i < 4; i++) u_mem.mem[e + 20'(i)] = v[8*i +: 8];
  endtask : put_vec

  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : summarize

  task automatic do_req(input logic [3:0] k, input logic [5:0] n, output int cyc, output int rds,
                        output logic idp);
    int a0;
    a0 = u_mem.ack_count;
    idp = 1'b0;
    cyc = 0;
    req_kind_i = k;
    req_num_i = n;
    req_valid_i = 1'b1;
    @(negedge clk_sys_i);
    req_valid_i = 1'b0;
    `CHK(busy_o, 1'b1)
    while (target_valid_o !== 1'b1 && cyc < 100) begin
      if (id_valid_o === 1'b1) idp = 1'b1;
      @(negedge clk_sys_i);
      cyc++;
    end
    if (id_valid_o === 1'b1) idp = 1'b1;
    `CHK(cyc < 100, 1'b1)
    `CHK(busy_o, 1'b0)
    rds = u_mem.ack_count - a0;
  endtask : do_req

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task automatic test_fixed;
    logic [19:0] fx [11] = '{20'hF_FFDC, 20'hF_FFE0, 20'hF_FFE4, 20'hF_FFE8, 20'hF_FFEC, 20'hF_FFF0,
                             20'hF_FFF0, 20'hF_FFF0, 20'hF_FFF4, 20'hF_FFF8, 20'hF_FFFC};
    int cyc, rds;
    logic idp;
    logic [31:0] v;
    for (int k = 0; k < 11; k++) put_vec(fx[k]);
    for (int k = 0; k < 11; k++) begin
      do_req(4'(k), 6'h00, cyc, rds, idp);
      v = vec_of(fx[k]);
      `CHK(entry_addr_o, fx[k])
      `CHK(target_o, v[19:0])
      `CHK(id_byte_o, v[31:24])
      `CHK(idp, 1'b1)
      `CHK(rds, 2)
    end
    $display("test_fixed done");
  endtask : test_fixed

  task automatic test_reloc(input logic [19:0] base, input int exp_rds, output int cyc_sum);
    logic [5:0] nums [5] = '{6'h00, 6'h01, 6'h07, 6'h0A, 6'h0D};
    logic [19:0] e;
    int cyc, rds;
    logic idp;
    vector_table_base_i = base;
    cyc_sum = 0;
    for (int i = 0; i < 5; i++) begin
      e = base + {12'h000, nums[i], 2'b00};
      put_vec(e);
      do_req(4'hB, nums[i], cyc, rds, idp);
      cyc_sum += cyc;
      `CHK(entry_addr_o, e)
      `CHK(target_o, 20'(vec_of(e)))
      `CHK(rds, exp_rds)
      `CHK(idp, 1'b0)
    end
  endtask : test_reloc

  task automatic test_speed;
    int cyc_e, cyc_o;
    test_reloc(20'h0_4000, 2, cyc_e);
    test_reloc(20'h0_4101, 4, cyc_o);
    `CHK(cyc_o > cyc_e, 1'b1)
    $display("test_speed done");
  endtask : test_speed

  task automatic test_redirect;
    int cyc, rds;
    logic idp;
    vector_table_base_i = 20'h0_8010;
    u_mem.wait_cycles = 3;
    put_vec(20'hF_FFE4);
    u_mem.mem[20'hF_FFE7] = 8'hFF;
    put_vec(20'h0_8010);
    do_req(4'h2, 6'h00, cyc, rds, idp);
    `CHK(entry_addr_o, 20'h0_8010)
    `CHK(target_o, 20'(vec_of(20'h0_8010)))
    `CHK(id_byte_o, ivag_pkg::BREAK_REDIRECT_BYTE)
    `CHK(idp, 1'b1)
    `CHK(rds, 4)
    u_mem.wait_cycles = 0;
    put_vec(20'hF_FFE4);
    // unused kind codes fall back to the relocatable table
    put_vec(20'h0_8018);
    do_req(4'hC, 6'h02, cyc, rds, idp);
    `CHK(entry_addr_o, 20'h0_8018)
    `CHK(target_o, 20'(vec_of(20'h0_8018)))
    `CHK(idp, 1'b0)
    $display("test_redirect done");
  endtask : test_redirect

  initial begin
    repeat (2) @(negedge clk_sys_i);
    srst_i = 1'b0;
    `CHK(target_valid_o, 1'b0)
    `CHK(busy_o, 1'b0)
    test_fixed();
    test_speed();
    test_redirect();
    summarize();
  end

  // whole run needs under two hundred cycles
  initial begin
    #(20 * 20000);
    fail_count++;
    summarize();
  end
endmodule : tb_interrupt_vector_address_gen
`undef CHK
`default_nettype wire
